// ==== i2c_client_condition_ack_logic.sv ====
// I2C client: condition handling, address match and acknowledge generation
// Operation
// - Bus idle when free and both lines high
// - Flag collision when SDA low while expecting high
// - Start is SDA fall with SCL high
// - Collision if SDA already low before driving
// - Stop is SDA rise with SCL high
// - Stop needs one SCL low after Start
// - Restart resets client logic like Start
// - 10-bit read needs prior match then Restart
// - Prior-match flag set and cleared as specified
// - Start/stop enables add interrupts in plain modes
// - Ninth pulse is acknowledge, transmitter releases SDA
// - Store sampled acknowledge into ack status
// - Hold enabled: software chooses acknowledge level
// - Holds disabled: hardware acknowledges automatically
// - No acknowledge when buffer full or overflow
// - Ack-time bit set after eighth falling edge
// - Ack-time bit works only with hold enabled
// - Four modes: 7/10-bit, with/without condition interrupts
// - Condition modes interrupt on Start, Restart, Stop
// - Compare first byte after Start with own address
// - Match loads buffer and interrupts; mismatch silent
// - Read sends bytes; write prepares reception
// - 7-bit match ignores address LSB
// - 10-bit high byte is 11110 A9 A8 0
// - Bytes MSB first, direction bit one reads
`timescale 1ns/1ps
module i2c_client_condition_ack_logic (
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset_n,
  // Bus pins
  input wire logic scl_pin,
  input wire logic sda_pin,
  output logic sda_out,
  output logic sda_oe,
  // Configuration
  input wire logic [1:0] port_mode_select,
  input wire logic [7:0] own_address_reg,
  input wire logic [7:0] own_address_low,
  input wire logic start_irq_enable,
  input wire logic stop_irq_enable,
  input wire logic address_hold_enable,
  input wire logic data_hold_enable,
  input wire logic ack_value_select,
  // Software buffer state and transmit data
  input wire logic buffer_full_flag,
  input wire logic receive_overflow_flag,
  input wire logic [7:0] tx_data,
  // Status and events
  output logic bus_active,
  output logic start_seen,
  output logic stop_seen,
  output logic bus_collision,
  output logic serial_port_irq_flag,
  output logic ack_status,
  output logic ack_time_status,
  output logic prior_match,
  output logic read_request,
  output logic [7:0] receive_buffer,
  output logic rx_valid,
  output logic tx_taken
);
  import i2c_client_pkg::*;

  logic scl_s, sda_s;
  logic start_det, stop_det, scl_rise, scl_fall;

  client_state_t state_q, state_d;
  logic [3:0] bit_cnt_q, bit_cnt_d;
  logic [7:0] shift_q, shift_d;
  logic ten_low_q, ten_low_d;
  logic prior_q, prior_d;
  logic read_q, read_d;
  logic sda_oe_q, sda_oe_d;
  logic ack_status_q, ack_status_d;
  logic ack_time_q, ack_time_d;
  logic [7:0] rx_buf_q, rx_buf_d;
  logic rx_valid_q, rx_valid_d;
  logic irq_q, irq_d;
  logic coll_q, coll_d;
  logic tx_taken_q, tx_taken_d;
  logic start_q, stop_q;

  logic ten_bit, cond_irq, hold_en, overflow, last_fall;
  logic [7:0] byte_in;
  logic hi_match, addr_match, ack_low;

  line_sync u_scl_sync (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .pin(scl_pin),
    .level(scl_s)
  );

  line_sync u_sda_sync (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .pin(sda_pin),
    .level(sda_s)
  );

  bus_condition_detect u_cond (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .scl_s(scl_s),
    .sda_s(sda_s),
    .start_det(start_det),
    .stop_det(stop_det),
    .scl_rise(scl_rise),
    .scl_fall(scl_fall),
    .bus_active(bus_active)
  );

  // Address decode on the byte just shifted in
  always_comb begin
    ten_bit = port_mode_select[MODE_TEN_BIT_POS];
    cond_irq = port_mode_select[MODE_COND_IRQ_POS];
    hold_en = address_hold_enable || data_hold_enable;
    overflow = buffer_full_flag || receive_overflow_flag;
    last_fall = scl_fall && (bit_cnt_q == BYTE_BITS);
    byte_in = shift_q;
    hi_match = byte_in[7:1] == {TEN_BIT_PREFIX, own_address_reg[OWN_A9_POS], own_address_reg[OWN_A8_POS]};
    if (!ten_bit) begin
      addr_match = byte_in[7:1] == own_address_reg[7:1];
    end else if (ten_low_q) begin
      addr_match = byte_in == own_address_low;
    end else begin
      // A read high byte only matches after a full write match
      addr_match = hi_match && (!byte_in[0] || prior_q);
    end
    // Software picks the level when holding, else hardware acks
    ack_low = !overflow && (hold_en ? !ack_value_select : 1'b1);
  end

  always_comb begin
    state_d = state_q;
    bit_cnt_d = bit_cnt_q;
    shift_d = shift_q;
    ten_low_d = ten_low_q;
    prior_d = prior_q;
    read_d = read_q;
    sda_oe_d = sda_oe_q;
    ack_status_d = ack_status_q;
    ack_time_d = ack_time_q;
    rx_buf_d = rx_buf_q;
    rx_valid_d = 1'b0;
    irq_d = 1'b0;
    coll_d = 1'b0;
    tx_taken_d = 1'b0;
    if (start_det) begin
      // Start and Restart alike reset state, bit count, ten-bit phase, SDA drive and ack time; prior match is kept
      state_d = ST_ADDR;
      bit_cnt_d = BIT_CNT_RESET;
      ten_low_d = 1'b0;
      sda_oe_d = 1'b0;
      ack_time_d = 1'b0;
      irq_d = cond_irq || start_irq_enable;
    end else if (stop_det) begin
      state_d = ST_IDLE;
      prior_d = 1'b0;
      sda_oe_d = 1'b0;
      ack_time_d = 1'b0;
      irq_d = cond_irq || stop_irq_enable;
    end else begin
      case (state_q)
        ST_ADDR, ST_RX: begin
          if (scl_rise) begin
            shift_d = {shift_q[6:0], sda_s};
            bit_cnt_d = bit_cnt_q + 4'd1;
          end else if (last_fall && state_q == ST_RX) begin
            rx_buf_d = byte_in;
            rx_valid_d = 1'b1;
            irq_d = 1'b1;
            sda_oe_d = ack_low;
            ack_time_d = hold_en;
            state_d = ST_RX_ACK;
          end else if (last_fall) begin
            if (ten_bit && !ten_low_q && (!hi_match || !byte_in[0])) begin
              prior_d = 1'b0;
            end
            if (!addr_match) begin
              state_d = ST_IDLE;
            end else begin
              if (ten_bit && ten_low_q) begin
                prior_d = 1'b1;
              end
              rx_buf_d = byte_in;
              rx_valid_d = 1'b1;
              irq_d = 1'b1;
              read_d = byte_in[0] && !(ten_bit && ten_low_q);
              sda_oe_d = ack_low;
              ack_time_d = hold_en;
              state_d = ST_ADDR_ACK;
            end
          end
        end
        ST_ADDR_ACK, ST_RX_ACK: begin
          if (scl_rise) begin
            ack_status_d = sda_s;
          end else if (scl_fall) begin
            sda_oe_d = 1'b0;
            ack_time_d = 1'b0;
            bit_cnt_d = BIT_CNT_RESET;
            if (!sda_oe_q) begin
              state_d = ST_IDLE;
            end else if (state_q == ST_ADDR_ACK && ten_bit && !ten_low_q && !read_q) begin
              ten_low_d = 1'b1;
              state_d = ST_ADDR;
            end else if (state_q == ST_ADDR_ACK && read_q) begin
              // First outgoing bit goes out on the acknowledge fall
              shift_d = {tx_data[6:0], 1'b0};
              sda_oe_d = !tx_data[7];
              tx_taken_d = 1'b1;
              state_d = ST_TX;
            end else begin
              ten_low_d = 1'b0;
              state_d = ST_RX;
            end
          end
        end
        ST_TX: begin
          if (scl_rise) begin
            bit_cnt_d = bit_cnt_q + 4'd1;
            if (!sda_oe_q && !sda_s) begin
              // Line low before we pulled it: another driver owns it
              coll_d = 1'b1;
              state_d = ST_IDLE;
            end
          end else if (last_fall) begin
            sda_oe_d = 1'b0;
            state_d = ST_TX_ACK;
          end else if (scl_fall) begin
            sda_oe_d = !shift_q[7];
            shift_d = {shift_q[6:0], 1'b0};
          end
        end
        ST_TX_ACK: begin
          if (scl_rise) begin
            ack_status_d = sda_s;
          end else if (scl_fall) begin
            irq_d = 1'b1;
            bit_cnt_d = BIT_CNT_RESET;
            if (ack_status_q) begin
              state_d = ST_IDLE;
            end else begin
              shift_d = {tx_data[6:0], 1'b0};
              sda_oe_d = !tx_data[7];
              tx_taken_d = 1'b1;
              state_d = ST_TX;
            end
          end
        end
        default: begin
          state_d = ST_IDLE;
          sda_oe_d = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      state_q <= ST_IDLE;
      bit_cnt_q <= BIT_CNT_RESET;
      shift_q <= BYTE_RESET;
      ten_low_q <= 1'b0;
      prior_q <= 1'b0;
      read_q <= 1'b0;
      sda_oe_q <= 1'b0;
      ack_status_q <= 1'b0;
      ack_time_q <= 1'b0;
      rx_buf_q <= BYTE_RESET;
      rx_valid_q <= 1'b0;
      irq_q <= 1'b0;
      coll_q <= 1'b0;
      tx_taken_q <= 1'b0;
      start_q <= 1'b0;
      stop_q <= 1'b0;
    end else begin
      state_q <= state_d;
      bit_cnt_q <= bit_cnt_d;
      shift_q <= shift_d;
      ten_low_q <= ten_low_d;
      prior_q <= prior_d;
      read_q <= read_d;
      sda_oe_q <= sda_oe_d;
      ack_status_q <= ack_status_d;
      ack_time_q <= ack_time_d;
      rx_buf_q <= rx_buf_d;
      rx_valid_q <= rx_valid_d;
      irq_q <= irq_d;
      coll_q <= coll_d;
      tx_taken_q <= tx_taken_d;
      start_q <= start_det;
      stop_q <= stop_det;
    end
  end

  // Open drain: the pad only ever pulls low
  assign sda_out = 1'b0;
  assign sda_oe = sda_oe_q;
  assign start_seen = start_q;
  assign stop_seen = stop_q;
  assign bus_collision = coll_q;
  assign serial_port_irq_flag = irq_q;
  assign ack_status = ack_status_q;
  assign ack_time_status = ack_time_q;
  assign prior_match = prior_q;
  assign read_request = read_q;
  assign receive_buffer = rx_buf_q;
  assign rx_valid = rx_valid_q;
  assign tx_taken = tx_taken_q;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);

  chk_start_enters_addr: assert property (start_det |=> state_q == ST_ADDR && !sda_oe_q)
    else $error("start did not return client to address phase");
  chk_stop_clears_prior: assert property (stop_det |=> state_q == ST_IDLE && !prior_q)
    else $error("stop did not idle client and clear prior match");
  chk_overflow_nack: assert property ((state_q == ST_ADDR || state_q == ST_RX) && last_fall && overflow |=> !sda_oe_q)
    else $error("acknowledge driven despite full buffer");
  chk_auto_ack: assert property ((state_q == ST_ADDR) && last_fall && addr_match && !hold_en && !overflow
    |=> sda_oe_q && state_q == ST_ADDR_ACK)
    else $error("matching address not acknowledged automatically");
  chk_ack_sampled: assert property ((state_q == ST_TX_ACK) && scl_rise && !start_det && !stop_det
    |=> ack_status_q == $past(sda_s))
    else $error("acknowledge level not stored");
  chk_ack_time_gate: assert property ($rose(ack_time_q) |-> $past(hold_en) && $past(last_fall))
    else $error("ack time set without hold or off the eighth fall");
  chk_collision_idle: assert property ((state_q == ST_TX) && scl_rise && !sda_oe_q && !sda_s && !start_det
    && !stop_det |=> bus_collision && state_q == ST_IDLE)
    else $error("collision not flagged");
  chk_cond_irq: assert property (start_det && cond_irq |=> serial_port_irq_flag && start_seen)
    else $error("start interrupt missing in condition mode");
  chk_tx_release: assert property (state_q == ST_TX_ACK |-> !sda_oe_q)
    else $error("transmitter holds SDA in acknowledge slot");
  chk_mismatch_silent: assert property ((state_q == ST_ADDR) && last_fall && !addr_match && !start_det
    && !stop_det |=> state_q == ST_IDLE && !serial_port_irq_flag && !rx_valid)
    else $error("mismatched address was reported");
endmodule : i2c_client_condition_ack_logic

// ==== i2c_client_pkg.sv ====
// Shared constants and state type for the I2C client condition and acknowledge logic
package i2c_client_pkg;
  localparam logic LINE_IDLE_LEVEL = 1'b1;
  localparam logic [4:0] TEN_BIT_PREFIX = 5'b11110;
  localparam logic [3:0] BYTE_BITS = 4'd8;
  localparam logic [3:0] BIT_CNT_RESET = 4'd0;
  localparam logic [7:0] BYTE_RESET = 8'h00;
  localparam int MODE_TEN_BIT_POS = 0;
  localparam int MODE_COND_IRQ_POS = 1;
  localparam int OWN_A9_POS = 2;
  localparam int OWN_A8_POS = 1;
  localparam int SYNC_STAGES = 3;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_ADDR = 3'b001,
    ST_ADDR_ACK = 3'b011,
    ST_RX = 3'b010,
    ST_RX_ACK = 3'b110,
    ST_TX = 3'b111,
    ST_TX_ACK = 3'b101
  } client_state_t;
endpackage : i2c_client_pkg

// ==== line_sync.sv ====
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
module line_sync (
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset_n,
  // Pin and filtered level
  input wire logic pin,
  output logic level
);
  import i2c_client_pkg::*;

  logic meta_q, meta_d;
  logic mid_q, mid_d;
  logic last_q, last_d;
  logic level_q, level_d;

  always_comb begin
    meta_d = pin;
    mid_d = meta_q;
    last_d = mid_q;
    // A change counts only once the two settled stages agree
    level_d = (mid_q == last_q) ? last_q : level_q;
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      meta_q <= LINE_IDLE_LEVEL;
      mid_q <= LINE_IDLE_LEVEL;
      last_q <= LINE_IDLE_LEVEL;
      level_q <= LINE_IDLE_LEVEL;
    end else begin
      meta_q <= meta_d;
      mid_q <= mid_d;
      last_q <= last_d;
      level_q <= level_d;
    end
  end

  assign level = level_q;
endmodule : line_sync

// ==== bus_condition_detect.sv ====
// Start, Stop and clock-edge detection with bus Idle/Active tracking
`timescale 1ns/1ps
module bus_condition_detect (
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset_n,
  // Synchronised lines
  input wire logic scl_s,
  input wire logic sda_s,
  // Events and state
  output logic start_det,
  output logic stop_det,
  output logic scl_rise,
  output logic scl_fall,
  output logic bus_active
);
  import i2c_client_pkg::*;

  logic scl_prev_q, scl_prev_d;
  logic sda_prev_q, sda_prev_d;
  logic low_seen_q, low_seen_d;
  logic active_q, active_d;

  always_comb begin
    scl_prev_d = scl_s;
    sda_prev_d = sda_s;
    start_det = scl_s && scl_prev_q && sda_prev_q && !sda_s;
    stop_det = scl_s && scl_prev_q && !sda_prev_q && sda_s && low_seen_q;
    scl_rise = scl_s && !scl_prev_q;
    scl_fall = !scl_s && scl_prev_q;
    low_seen_d = low_seen_q;
    active_d = active_q;
    if (start_det) begin
      // A glitch low and high on SDA with SCL high yields only a Start
      low_seen_d = 1'b0;
      active_d = 1'b1;
    end else if (stop_det) begin
      low_seen_d = 1'b0;
      active_d = 1'b0;
    end else if (!scl_s) begin
      low_seen_d = 1'b1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      scl_prev_q <= LINE_IDLE_LEVEL;
      sda_prev_q <= LINE_IDLE_LEVEL;
      low_seen_q <= 1'b0;
      active_q <= 1'b0;
    end else begin
      scl_prev_q <= scl_prev_d;
      sda_prev_q <= sda_prev_d;
      low_seen_q <= low_seen_d;
      active_q <= active_d;
    end
  end

  // Idle needs no host in control and both lines high
  assign bus_active = active_q || !scl_s || !sda_s;
endmodule : bus_condition_detect

// ==== i2c_host_model.sv ====
// Behavioural I2C host that drives SCL and clocks bytes in and out over open-drain SDA
`timescale 1ns/1ps
module i2c_host_model #(
  parameter int HALF_NS = 40
) (
  // Bus lines
  output logic scl,
  output logic sda_rel,
  input wire logic sda
);
  initial begin
    scl = 1'b1;
    sda_rel = 1'b1;
  end

  // Restart pulls SCL low first so the client can let go of its acknowledge
  task automatic start_c(input logic rep);
    if (rep) begin
      scl = 1'b0;
      #HALF_NS;
    end
    sda_rel = 1'b1;
    #(HALF_NS / 2);
    scl = 1'b1;
    #HALF_NS;
    sda_rel = 1'b0;
    // Long enough for the client's sync and detect latency to show the condition
    #(2 * HALF_NS);
  endtask : start_c

  task automatic stop_c;
    scl = 1'b0;
    #HALF_NS;
    sda_rel = 1'b0;
    #(HALF_NS / 2);
    scl = 1'b1;
    #HALF_NS;
    sda_rel = 1'b1;
    #(2 * HALF_NS);
  endtask : stop_c

  // SDA falls and rises again with no SCL low in between
  task automatic glitch;
    sda_rel = 1'b0;
    #HALF_NS;
    sda_rel = 1'b1;
    #(2 * HALF_NS);
  endtask : glitch

  // Data changes only while SCL is low, sampled mid-way through SCL high
  // Low phase is kept long: the client moves SDA about five core cycles after it sees SCL fall
  task automatic bit_io(input logic b, output logic r);
    scl = 1'b0;
    #(HALF_NS / 4);
    sda_rel = b;
    #(HALF_NS + HALF_NS / 4);
    scl = 1'b1;
    #(HALF_NS / 4);
    r = sda;
    #(HALF_NS / 4);
  endtask : bit_io

  // Eight bits MSB first, then the ninth acknowledge slot
  task automatic xfer(input logic [7:0] d, input logic ack_in, output logic [7:0] q, output logic ack_out);
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], q[i]);
    end
    bit_io(ack_in, ack_out);
  endtask : xfer
endmodule : i2c_host_model

// ==== test_i2c_client_condition_ack_logic.sv ====
// Self-checking bench for the I2C client condition and acknowledge logic
`timescale 1ns/1ps
`define CHECK(got, exp) begin comparisons++; if ((got) !== (exp)) begin num_errors++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp); end end
module test_i2c_client_condition_ack_logic;
  import i2c_client_pkg::*;
  logic core_clk = 1'b0;
  logic reset_n = 1'b0;
  logic scl, sda_rel, sda_oe, sda_line, a, e_ok;
  logic [1:0] mode = 2'h0;
  logic [7:0] own = 8'ha4, own_low = 8'h00, tx = 8'h00, rx_buf, q, d, e;
  logic sie = 1'b0, pie = 1'b0, hold_a = 1'b0, hold_d = 1'b0, ack_sel = 1'b0, buf_full = 1'b0, rx_ovf = 1'b0;
  logic bus_active, start_seen, stop_seen, coll, irq, ack_status, ack_time_status, prior_match, rx_valid;
  logic strict = 1'b1, at_seen = 1'b0;
  logic [7:0] n_start = 8'h00, n_stop = 8'h00, n_irq = 8'h00, n_coll = 8'h00, n_tx = 8'h00, hi;
  logic sda_out_w, rd_req, tx_tk;
  logic [7:0] exp_q[$];
  int num_errors = 0, comparisons = 0, cycles = 0, seed = 21518;

  assign sda_line = sda_rel & (~sda_oe | sda_out_w);
  always #5 core_clk = ~core_clk;

  i2c_host_model i2c_host_model_inst (.scl(scl), .sda_rel(sda_rel), .sda(sda_line));
  i2c_client_condition_ack_logic i2c_client_condition_ack_logic_inst (.core_clk(core_clk), .reset_n(reset_n),
    .scl_pin(scl), .sda_pin(sda_line), .sda_out(sda_out_w), .sda_oe(sda_oe), .port_mode_select(mode),
    .own_address_reg(own), .own_address_low(own_low), .start_irq_enable(sie), .stop_irq_enable(pie),
    .address_hold_enable(hold_a), .data_hold_enable(hold_d), .ack_value_select(ack_sel),
    .buffer_full_flag(buf_full), .receive_overflow_flag(rx_ovf), .tx_data(tx), .bus_active(bus_active),
    .start_seen(start_seen), .stop_seen(stop_seen), .bus_collision(coll), .serial_port_irq_flag(irq),
    .ack_status(ack_status), .ack_time_status(ack_time_status), .prior_match(prior_match),
    .read_request(rd_req), .receive_buffer(rx_buf), .rx_valid(rx_valid), .tx_taken(tx_tk));

  // Watcher: counts event pulses and, while strict is set, matches each loaded byte against the oldest note
  always @(negedge core_clk) begin
    n_start += start_seen;
    n_stop += stop_seen;
    n_irq += irq;
    n_coll += coll;
    n_tx += tx_tk;
    if (ack_time_status) at_seen = 1'b1;
    if (rx_valid && strict) begin
      e = (exp_q.size() > 0) ? exp_q.pop_front() : 8'hxx;
      `CHECK(rx_buf, e)
    end
  end

  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 40000) begin
      num_errors++;
      finish_test();
    end
  end

  task automatic tick;
    @(posedge core_clk);
    #1;
  endtask : tick

  task automatic clr;
    tick();
    {n_start, n_stop, n_irq, n_coll} = 32'h0;
    n_tx = 8'h00;
    at_seen = 1'b0;
  endtask : clr

  task automatic done(input string s);
    $display("test %s done", s);
    exp_q.delete();
    strict = 1'b1;
  endtask : done

  task automatic wr(input logic [7:0] v, input logic ack, input logic push);
    if (push) exp_q.push_back(v);
    i2c_host_model_inst.xfer(v, 1'b1, q, a);
    `CHECK(a, ack)
  endtask : wr

  task automatic rd(input logic host_ack);
    i2c_host_model_inst.xfer(8'hff, host_ack, q, a);
  endtask : rd

  task automatic finish_test;
    $display("comparisons=%0d num_errors=%0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : finish_test

  initial begin
    repeat (12) @(posedge core_clk);
    #1 reset_n = 1'b1;
    repeat (6) tick();
    clr();
    own = 8'($random(seed));
    // Ignored while both holds are off
    ack_sel = 1'($random(seed));
    i2c_host_model_inst.start_c(1'b0);
    `CHECK(bus_active, 1'b1)
    wr({own[7:1], 1'b0}, 1'b0, 1'b1);
    for (int i = 0; i < 2; i++) begin
      d = 8'($random(seed));
      wr(d, 1'b0, 1'b1);
    end
    `CHECK(rd_req, 1'b0)
    i2c_host_model_inst.stop_c();
    `CHECK(bus_active, 1'b0)
    `CHECK({n_start, n_stop, n_irq, at_seen}, {8'h01, 8'h01, 8'h03, 1'b0})
    `CHECK(exp_q.size(), 0)
    done("write");
    clr();
    i2c_host_model_inst.start_c(1'b0);
    wr({~own[7:1], 1'b0}, 1'b1, 1'b0);
    i2c_host_model_inst.stop_c();
    `CHECK({n_start, n_irq}, 16'h0100)
    done("mismatch");
    for (int i = 0; i < 2; i++) begin
      clr();
      {buf_full, rx_ovf} = (i == 0) ? 2'b10 : 2'b01;
      strict = 1'b0;
      i2c_host_model_inst.start_c(1'b0);
      wr({own[7:1], 1'b0}, 1'b1, 1'b0);
      i2c_host_model_inst.stop_c();
      tick();
      {buf_full, rx_ovf} = 2'b00;
      done("overflow");
    end
    for (int i = 1; i < 3; i++) begin
      clr();
      {hold_a, hold_d} = 2'(i);
      ack_sel = 1'b1;
      strict = 1'b0;
      i2c_host_model_inst.start_c(1'b0);
      wr({own[7:1], 1'b0}, 1'b1, 1'b0);
      i2c_host_model_inst.stop_c();
      `CHECK(at_seen, 1'b1)
      tick();
      ack_sel = 1'b0;
      i2c_host_model_inst.start_c(1'b0);
      wr({own[7:1], 1'b0}, 1'b0, 1'b0);
      i2c_host_model_inst.stop_c();
      tick();
      {hold_a, hold_d} = 2'b00;
      done("hold");
    end
    clr();
    tx = 8'($random(seed));
    d = tx;
    i2c_host_model_inst.start_c(1'b0);
    wr({own[7:1], 1'b1}, 1'b0, 1'b1);
    `CHECK(rd_req, 1'b1)
    rd(1'b0);
    `CHECK(q, d)
    // The ninth rise reaches the status bit only after the sync latency
    repeat (4) tick();
    `CHECK(ack_status, 1'b0)
    tx = ~d;
    rd(1'b1);
    `CHECK(q, ~d)
    repeat (4) tick();
    `CHECK(ack_status, 1'b1)
    i2c_host_model_inst.stop_c();
    `CHECK(n_tx, 8'h02)
    done("read");
    clr();
    tx = 8'hff;
    i2c_host_model_inst.start_c(1'b0);
    wr({own[7:1], 1'b1}, 1'b0, 1'b1);
    i2c_host_model_inst.xfer(8'h00, 1'b1, q, a);
    i2c_host_model_inst.stop_c();
    `CHECK(n_coll, 8'h01)
    done("collision");
    for (int i = 0; i < 3; i++) begin
      clr();
      {mode[1], sie, pie} = (i == 0) ? 3'b100 : ((i == 1) ? 3'b011 : 3'b111);
      i2c_host_model_inst.start_c(1'b0);
      wr({~own[7:1], 1'b0}, 1'b1, 1'b0);
      i2c_host_model_inst.start_c(1'b1);
      wr({~own[7:1], 1'b0}, 1'b1, 1'b0);
      i2c_host_model_inst.stop_c();
      `CHECK({n_start, n_stop, n_irq}, 24'h020103)
      tick();
      {mode, sie, pie} = 4'h0;
      done("condition irq");
    end
    clr();
    i2c_host_model_inst.glitch();
    `CHECK({n_start, n_stop}, 16'h0100)
    i2c_host_model_inst.stop_c();
    `CHECK(n_stop, 8'h01)
    done("short stop");
    clr();
    mode = 2'b01;
    own = 8'($random(seed));
    hi = {TEN_BIT_PREFIX, own[2:1], 1'b0};
    own_low = 8'($random(seed));
    tx = 8'($random(seed));
    d = tx;
    strict = 1'b0;
    i2c_host_model_inst.start_c(1'b0);
    wr(hi | 8'h01, 1'b1, 1'b0);
    i2c_host_model_inst.start_c(1'b1);
    wr(hi, 1'b0, 1'b0);
    wr(own_low, 1'b0, 1'b0);
    `CHECK(prior_match, 1'b1)
    i2c_host_model_inst.start_c(1'b1);
    wr(hi | 8'h01, 1'b0, 1'b0);
    rd(1'b1);
    `CHECK(q, d)
    i2c_host_model_inst.stop_c();
    `CHECK(prior_match, 1'b0)
    done("ten bit");
    finish_test();
  end
endmodule : test_i2c_client_condition_ack_logic
